/* File: rtl/vfb_pkg.sv */
// shared constants and types for the video frame buffer controller
package vfb_pkg;
  // precharge and service timing, in system clocks
  localparam logic [2:0] ROW_RECOVERY_TIMER_FAR_CLKS = 3'h3;
  localparam logic [2:0] ROW_RECOVERY_TIMER_SVC_CLKS = 3'h4;
  localparam logic [2:0] SVC_ACT_CLKS   = 3'h5;
  // serial side
  localparam int PIXELS_PER_LOAD = 4;
  localparam int PIXEL_WIDTH     = 8;
  localparam int LINE_PIXELS     = 1024;
  localparam int PIXEL_DIV       = 4;
  // reset values
  localparam logic PORT_SEL_RESET = 1'b0;

  typedef enum logic [2:0] {
    VFB_IDLE    = 3'b000,
    VFB_ROW     = 3'b001,
    VFB_COL     = 3'b011,
    VFB_ROW_RECOVERY_TIMER   = 3'b010,
    VFB_SVC_DLY = 3'b110,
    VFB_SVC_ACT = 3'b111,
    VFB_WRITE_AFTER_READ_DELAY    = 3'b101
  } vfb_state_t;

  typedef enum logic [1:0] {
    VFB_SEL_IDLE  = 2'b00,
    VFB_SEL_LATCH = 2'b01,
    VFB_SEL_READY = 2'b11
  } vfb_sel_t;
endpackage

/* File: rtl/vfb_serial_if.sv */
// link between controller core and serial shift logic
`timescale 1ns/1ps
interface vfb_serial_if;
  logic blank;
  logic load_n;
  logic clear_n;
  modport ctrl (output blank, input load_n, input clear_n);
  modport ser  (input blank, output load_n, output clear_n);
endinterface

/* File: rtl/vfb_serial.sv */
// serial side: four-pixel load, shift on pixel enable, clear at line end
`timescale 1ns/1ps
module vfb_serial
  import vfb_pkg::*;
#(
  parameter int PIX_W  = PIXEL_WIDTH,
  parameter int NPIX   = PIXELS_PER_LOAD,
  parameter int LINE   = LINE_PIXELS,
  parameter int DIV    = PIXEL_DIV
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  vfb_serial_if.ser                  sif,
  input  wire logic [NPIX*PIX_W-1:0] video_data,
  output logic      [PIX_W-1:0]      pixel_out,
  output logic                       serial_clock
);
  localparam int DW = $clog2(DIV);
  localparam int LW = $clog2(LINE + 1);

  logic [DW-1:0]        div_reg, div_next;
  logic [1:0]           ph_reg, ph_next;
  logic [LW-1:0]        cnt_reg, cnt_next;
  logic [NPIX*PIX_W-1:0] sh_reg, sh_next;
  logic                 pix_en, load, clr;

  always_comb begin
    pix_en   = (div_reg == DW'(DIV - 1));
    div_next = pix_en ? '0 : div_reg + DW'(1);
    load     = pix_en && (ph_reg == 2'h0) && !sif.blank
               && (cnt_reg < LW'(LINE));
    clr      = pix_en && (cnt_reg == LW'(LINE));
    ph_next  = ph_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    if (sif.blank) begin
      // the shift register clears during blanking; restart the line count
      cnt_next = '0;
      ph_next  = 2'h0;
      sh_next  = '0;
    end else if (clr) begin
      sh_next  = '0;
    end else if (pix_en && cnt_reg < LW'(LINE)) begin
      ph_next  = ph_reg + 2'h1;
      cnt_next = cnt_reg + LW'(1);
      if (load)
        sh_next = video_data;
      else
        sh_next = sh_reg >> PIX_W;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
      ph_reg  <= '0;
      cnt_reg <= '0;
      sh_reg  <= '0;
    end else begin
      div_reg <= div_next;
      ph_reg  <= ph_next;
      cnt_reg <= cnt_next;
      sh_reg  <= sh_next;
    end
  end

  assign pixel_out    = sh_reg[PIX_W-1:0];
  assign serial_clock = load;
  assign sif.load_n   = !load;
  assign sif.clear_n  = !clr;
endmodule // vfb_serial

/* File: rtl/vfb_ctrl.sv */
// video frame buffer controller: strobes, arbitration, ready and busy
`timescale 1ns/1ps
module vfb_ctrl
  import vfb_pkg::*;
(
  input  wire logic                                 clock,
  input  wire logic                                 arst_n,
  input  wire logic                                 cycle_start,
  input  wire logic                                 write_cycle,
  input  wire logic                                 addr_bit22,
  input  wire logic                                 addr_bit21,
  input  wire logic                                 addr_bit3,
  input  wire logic                                 expansion_space_select_n,
  input  wire logic                                 same_page_indicator_n,
  input  wire logic                                 dram_busy_n,
  input  wire logic                                 other_busy_n,
  input  wire logic                                 core_renew_request,
  input  wire logic                                 line_blank,
  input  wire logic                                 zero_wait_mode,
  input  wire logic [PIXELS_PER_LOAD*PIXEL_WIDTH-1:0] video_data,
  output logic                                      row_strobe_buffer_one_n,
  output logic                                      row_strobe_buffer_zero_n,
  output logic                                      column_strobe_copy_zero_n,
  output logic                                      column_strobe_copy_one_n,
  output logic                                      column_strobe_copy_two_n,
  output logic                                      memory_write_strobe_n,
  output logic                                      output_or_transfer_strobe_n,
  output logic                                      row_addr_enable_n,
  output logic                                      col_addr_enable_n,
  output logic                                      serial_row_addr_enable_n,
  output logic                                      serial_col_addr_enable_n,
  output logic                                      row_strobe_delay_n,
  output logic                                      merged_service_request_n,
  output logic                                      cycle_pending_n,
  output logic                                      read_data_latch_n,
  output logic                                      write_data_latch_n,
  output logic                                      renew_request_clear_n,
  output logic                                      transfer_request_clear_n,
  output logic                                      processor_ready_n,
  output logic                                      expansion_busy_n,
  output logic                                      combined_busy_n,
  output logic                                      serial_port_zero_select_n,
  output logic                                      serial_port_one_select_n,
  output logic                                      shift_register_load_n,
  output logic                                      shift_register_empty_clear_n,
  output logic [PIXEL_WIDTH-1:0]                    pixel_out,
  output logic                                      serial_clock
);
  import vfb_pkg::*;

  vfb_state_t state_reg, state_next;
  vfb_sel_t   sel_reg, sel_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       pend_reg, pend_next;
  logic       pwr_reg, pwr_next;       // pending access is a write
  logic       pa21_reg, pa21_next;
  logic       cwr_reg, cwr_next;       // access in flight is a write
  logic       ca21_reg, ca21_next;
  logic       lastrd_reg, lastrd_next;
  logic       wdret_reg, wdret_next;   // write delay returns to column
  logic       renew_reg, renew_next;
  logic       xfer_reg, xfer_next;
  logic       kind_reg, kind_next;     // 1 = refresh, 0 = transfer
  logic       port_reg, port_next;
  logic       blank_s1_reg, blank_s2_reg, blank_s3_reg;
  logic       hit, sel_hit, svc_req, svc_timer, clr_pulse;

  vfb_serial_if sif ();

  // line blank comes from the pixel domain, so it is resynchronised
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blank_s1_reg <= 1'b0;
      blank_s2_reg <= 1'b0;
      blank_s3_reg <= 1'b0;
    end else begin
      blank_s1_reg <= line_blank;
      blank_s2_reg <= blank_s1_reg;
      blank_s3_reg <= blank_s2_reg;
    end
  end
  assign sif.blank = blank_s2_reg;

  always_comb begin
    hit       = cycle_start && !expansion_space_select_n && !addr_bit22
                && dram_busy_n;
    sel_hit   = cycle_start && !expansion_space_select_n && addr_bit22;
    svc_req   = renew_reg || xfer_reg;
    svc_timer = (state_reg == VFB_SVC_ACT);
    clr_pulse = svc_timer && (cnt_reg == 3'h1);

    state_next  = state_reg;
    cnt_next    = cnt_reg;
    pend_next   = pend_reg;
    pwr_next    = pwr_reg;
    pa21_next   = pa21_reg;
    cwr_next    = cwr_reg;
    ca21_next   = ca21_reg;
    lastrd_next = lastrd_reg;
    wdret_next  = wdret_reg;
    kind_next   = kind_reg;

    // a set in the clearing cycle wins
    renew_next = core_renew_request
                 || (renew_reg && !(clr_pulse && kind_reg));
    xfer_next  = (blank_s2_reg && !blank_s3_reg)
                 || (xfer_reg && !(clr_pulse && !kind_reg));

    if (hit) begin
      pend_next = 1'b1;
      pwr_next  = write_cycle;
      pa21_next = addr_bit21;
    end else if (state_reg == VFB_COL) begin
      pend_next = 1'b0;
    end

    case (state_reg)
      VFB_IDLE: begin
        if (svc_req) begin
          kind_next  = renew_reg;
          state_next = VFB_SVC_DLY;
        end else if (pend_reg) begin
          cwr_next   = pwr_reg;
          ca21_next  = pa21_reg;
          wdret_next = 1'b0;
          state_next = (pwr_reg && lastrd_reg) ? VFB_WRITE_AFTER_READ_DELAY : VFB_ROW;
        end
      end
      VFB_ROW: state_next = VFB_COL;
      VFB_COL: begin
        lastrd_next = !cwr_reg;
        if (hit && !same_page_indicator_n && !svc_req
            && addr_bit21 == ca21_reg) begin
          cwr_next   = write_cycle;
          wdret_next = 1'b1;
          if (write_cycle && !cwr_reg)
            state_next = VFB_WRITE_AFTER_READ_DELAY;
        end else begin
          cnt_next   = svc_req ? ROW_RECOVERY_TIMER_SVC_CLKS : ROW_RECOVERY_TIMER_FAR_CLKS;
          state_next = VFB_ROW_RECOVERY_TIMER;
        end
      end
      VFB_WRITE_AFTER_READ_DELAY: begin
        lastrd_next = 1'b0;
        state_next  = wdret_reg ? VFB_COL : VFB_ROW;
      end
      VFB_ROW_RECOVERY_TIMER: begin
        cnt_next = cnt_reg - 3'h1;
        if (cnt_reg == 3'h1) begin
          if (svc_req) begin
            kind_next  = renew_reg;
            state_next = VFB_SVC_DLY;
          end else if (pend_reg) begin
            cwr_next   = pwr_reg;
            ca21_next  = pa21_reg;
            wdret_next = 1'b0;
            state_next = (pwr_reg && lastrd_reg) ? VFB_WRITE_AFTER_READ_DELAY : VFB_ROW;
          end else begin
            state_next = VFB_IDLE;
          end
        end
      end
      VFB_SVC_DLY: begin
        cnt_next   = SVC_ACT_CLKS;
        state_next = VFB_SVC_ACT;
      end
      VFB_SVC_ACT: begin
        cnt_next = cnt_reg - 3'h1;
        if (cnt_reg == 3'h1) begin
          cnt_next   = xfer_next || renew_next
                       ? ROW_RECOVERY_TIMER_SVC_CLKS : ROW_RECOVERY_TIMER_FAR_CLKS;
          state_next = VFB_ROW_RECOVERY_TIMER;
        end
      end
      default: state_next = VFB_IDLE;
    endcase

    // selection accesses sequenced by two state bits
    sel_next  = sel_reg;
    port_next = port_reg;
    case (sel_reg)
      VFB_SEL_IDLE: if (sel_hit) begin
        port_next = addr_bit3;
        sel_next  = VFB_SEL_LATCH;
      end
      VFB_SEL_LATCH: sel_next = VFB_SEL_READY;
      VFB_SEL_READY: sel_next = VFB_SEL_IDLE;
      default:       sel_next = VFB_SEL_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= VFB_IDLE;
      sel_reg    <= VFB_SEL_IDLE;
      cnt_reg    <= 3'h0;
      pend_reg   <= 1'b0;
      pwr_reg    <= 1'b0;
      pa21_reg   <= 1'b0;
      cwr_reg    <= 1'b0;
      ca21_reg   <= 1'b0;
      lastrd_reg <= 1'b0;
      wdret_reg  <= 1'b0;
      renew_reg  <= 1'b0;
      xfer_reg   <= 1'b0;
      kind_reg   <= 1'b0;
      port_reg   <= PORT_SEL_RESET;
    end else begin
      state_reg  <= state_next;
      sel_reg    <= sel_next;
      cnt_reg    <= cnt_next;
      pend_reg   <= pend_next;
      pwr_reg    <= pwr_next;
      pa21_reg   <= pa21_next;
      cwr_reg    <= cwr_next;
      ca21_reg   <= ca21_next;
      lastrd_reg <= lastrd_next;
      wdret_reg  <= wdret_next;
      renew_reg  <= renew_next;
      xfer_reg   <= xfer_next;
      kind_reg   <= kind_next;
      port_reg   <= port_next;
    end
  end

  // strobe decode from registered state, except the zero-wait write data latch, which decodes hit from the inputs
  logic row_on, col_on, svc_on;
  always_comb begin
    row_on = (state_reg == VFB_ROW) || (state_reg == VFB_COL)
             || (state_reg == VFB_WRITE_AFTER_READ_DELAY && wdret_reg);
    svc_on = (state_reg == VFB_SVC_DLY) || svc_timer;
    col_on = (state_reg == VFB_COL) || (state_reg == VFB_WRITE_AFTER_READ_DELAY && wdret_reg)
             || (svc_on && kind_reg);      // column before row for refresh
  end

  assign row_strobe_buffer_one_n  = !((row_on && !ca21_reg) || svc_timer);
  assign row_strobe_buffer_zero_n = !((row_on && ca21_reg) || svc_timer);
  // copies only spread load; one term keeps them identical
  assign column_strobe_copy_zero_n = !col_on;
  assign column_strobe_copy_one_n  = !col_on;
  assign column_strobe_copy_two_n  = !col_on;
  assign memory_write_strobe_n = !((state_reg == VFB_COL) && cwr_reg
                                   && !svc_on);
  assign output_or_transfer_strobe_n =
    !(((state_reg == VFB_COL) && !cwr_reg) || (svc_on && !kind_reg));
  assign row_addr_enable_n        = !(state_reg == VFB_ROW);
  assign col_addr_enable_n        = !(state_reg == VFB_COL);
  assign serial_row_addr_enable_n = !(svc_on && !kind_reg
                                      && state_reg == VFB_SVC_DLY);
  assign serial_col_addr_enable_n = !(svc_timer && !kind_reg);
  assign row_strobe_delay_n       = !(state_reg == VFB_SVC_DLY);
  assign merged_service_request_n = !svc_req;
  assign cycle_pending_n          = !pend_reg;
  assign read_data_latch_n = !((state_reg == VFB_COL) && !cwr_reg);
  assign write_data_latch_n = zero_wait_mode ? !hit
                              : !((state_reg == VFB_COL) && cwr_reg);
  assign renew_request_clear_n    = !(clr_pulse && kind_reg);
  assign transfer_request_clear_n = !(clr_pulse && !kind_reg);
  assign processor_ready_n = !((state_reg == VFB_COL)
                               || (sel_reg == VFB_SEL_READY));
  assign expansion_busy_n = !(pend_reg || state_reg != VFB_IDLE);
  assign combined_busy_n  = expansion_busy_n && other_busy_n;
  // one register drives both, so they can never be low together
  assign serial_port_zero_select_n = port_reg;
  assign serial_port_one_select_n  = !port_reg;
  assign shift_register_load_n        = sif.load_n;
  assign shift_register_empty_clear_n = sif.clear_n;

  vfb_serial u_serial (
    .clock        (clock),
    .arst_n       (arst_n),
    .sif          (sif),
    .video_data   (video_data),
    .pixel_out    (pixel_out),
    .serial_clock (serial_clock)
  );
endmodule // vfb_ctrl

/* File: rtl/vfb_top_unused_placeholder_none.sv */
// intentionally empty file holder
`timescale 1ns/1ps

/* File: bench/vfb_ctrl_asserts.sv */
// port-level assertions for the frame buffer controller
`timescale 1ns/1ps
module vfb_ctrl_asserts (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cycle_start,
  input wire logic addr_bit22,
  input wire logic expansion_space_select_n,
  input wire logic dram_busy_n,
  input wire logic other_busy_n,
  input wire logic core_renew_request,
  input wire logic zero_wait_mode,
  input wire logic row_strobe_buffer_one_n,
  input wire logic row_strobe_buffer_zero_n,
  input wire logic column_strobe_copy_zero_n,
  input wire logic column_strobe_copy_one_n,
  input wire logic column_strobe_copy_two_n,
  input wire logic memory_write_strobe_n,
  input wire logic row_strobe_delay_n,
  input wire logic merged_service_request_n,
  input wire logic cycle_pending_n,
  input wire logic write_data_latch_n,
  input wire logic processor_ready_n,
  input wire logic expansion_busy_n,
  input wire logic combined_busy_n,
  input wire logic serial_port_zero_select_n,
  input wire logic serial_port_one_select_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire svc = !row_strobe_buffer_one_n && !row_strobe_buffer_zero_n;
  wire rows_hi = row_strobe_buffer_one_n && row_strobe_buffer_zero_n;
  wire sel = cycle_start && !expansion_space_select_n && addr_bit22;
  wire hit = cycle_start && !expansion_space_select_n && !addr_bit22 &&
             dram_busy_n;

  a_cas_copies: assert property (
    column_strobe_copy_zero_n == column_strobe_copy_one_n &&
    column_strobe_copy_one_n == column_strobe_copy_two_n)
    else $error("column strobe copies differ");
  a_port_onehot: assert property (
    serial_port_zero_select_n != serial_port_one_select_n)
    else $error("serial port selects not exactly one");
  a_req_merge: assert property (
    core_renew_request |=> !merged_service_request_n)
    else $error("renew request not merged");
  a_svc_width: assert property (
    $rose(svc) |-> svc[*5] ##1 rows_hi)
    else $error("service row strobe width wrong");
  a_svc_delay: assert property (
    $rose(svc) |-> !$past(row_strobe_delay_n))
    else $error("service row fall not delayed");
  a_svc_no_write: assert property (
    svc |-> memory_write_strobe_n)
    else $error("write strobe during service");
  a_busy_merge: assert property (
    combined_busy_n == (expansion_busy_n && other_busy_n))
    else $error("combined busy wrong");
  a_hit_pending: assert property (
    hit |=> !cycle_pending_n)
    else $error("hit did not raise pending");
  a_sel_ready: assert property (
    sel |-> ##2 !processor_ready_n)
    else $error("select access ready late");
  a_zw_latch: assert property (
    zero_wait_mode && hit |-> !write_data_latch_n)
    else $error("zero-wait write latch missing");
  a_row_row_recovery_timer: assert property (
    $rose(row_strobe_buffer_one_n) |-> row_strobe_buffer_one_n[*3])
    else $error("row precharge too short");
endmodule // vfb_ctrl_asserts

/* File: bench/vfb_core_model.sv */
// core glue stand-in: renew request pulse and read data capture
`timescale 1ns/1ps
module vfb_core_model (
  input wire logic  clock,
  input wire logic  arst_n,
  input wire logic  renew_kick,
  input wire logic  read_data_latch_n,
  output logic      core_renew_request,
  output logic [7:0] captures
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_renew_request <= 1'h0;
      captures <= 8'h00;
    end else begin
      // the kick delayed one clock; the bench pulses it, so a held level cannot re-set the request after its clear
      core_renew_request <= renew_kick;
      if (!read_data_latch_n) captures <= captures + 8'h01;
    end
  end
endmodule // vfb_core_model

/* File: bench/vfb_ctrl_test.sv */
// self-checking bench for the frame buffer controller
`timescale 1ns/1ps
module vfb_ctrl_test;
  import vfb_pkg::*;
  typedef struct packed {
    logic [4:0] in;
    logic [3:0] n;
    logic [5:0] v;
    logic [1:0] p;
  } vfb_row_t;
  // in = {write, select_n, bit22, bit21, bit3}
  vfb_row_t rows [6] = '{'{5'h10, 4'h3, 6'h15, 2'h1},
    '{5'h12, 4'h3, 6'h25, 2'h1}, '{5'h00, 4'h3, 6'h12, 2'h1},
    '{5'h02, 4'h3, 6'h22, 2'h1}, '{5'h05, 4'h2, 6'h3f, 2'h2},
    '{5'h04, 4'h2, 6'h3f, 2'h1}};
  logic clock = 1'h0, arst_n = 1'h0, renew_kick;
  logic cycle_start, write_cycle, addr_bit22, addr_bit21, addr_bit3;
  logic expansion_space_select_n, same_page_indicator_n, dram_busy_n;
  logic other_busy_n, core_renew_request, line_blank, zero_wait_mode;
  logic [PIXELS_PER_LOAD*PIXEL_WIDTH-1:0] video_data;
  logic row_strobe_buffer_one_n, row_strobe_buffer_zero_n;
  logic column_strobe_copy_zero_n, column_strobe_copy_one_n;
  logic column_strobe_copy_two_n, memory_write_strobe_n;
  logic output_or_transfer_strobe_n, row_addr_enable_n, col_addr_enable_n;
  logic serial_row_addr_enable_n, serial_col_addr_enable_n;
  logic row_strobe_delay_n, merged_service_request_n, cycle_pending_n;
  logic read_data_latch_n, write_data_latch_n, renew_request_clear_n;
  logic transfer_request_clear_n, processor_ready_n, expansion_busy_n;
  logic combined_busy_n, serial_port_zero_select_n, serial_port_one_select_n;
  logic shift_register_load_n, shift_register_empty_clear_n, serial_clock;
  logic [PIXEL_WIDTH-1:0] pixel_out;
  logic [7:0] captures;
  int fails = 0, cmp_count = 0, cyc = 0;
  logic [7:0] xs, rd, sr;
  wire [5:0] strobes = {row_strobe_buffer_one_n, row_strobe_buffer_zero_n,
    column_strobe_copy_zero_n, read_data_latch_n, write_data_latch_n,
    output_or_transfer_strobe_n};
  wire [1:0] ports = {serial_port_zero_select_n, serial_port_one_select_n};

  vfb_ctrl dut (.*);
  vfb_core_model core (
    .clock             (clock),
    .arst_n            (arst_n),
    .renew_kick        (renew_kick),
    .read_data_latch_n (read_data_latch_n),
    .core_renew_request(core_renew_request),
    .captures          (captures)
  );

  always #2 clock = ~clock;

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic go(input logic [4:0] in, output logic zl);
    @(posedge clock);
    cycle_start <= 1'h1;
    {write_cycle, expansion_space_select_n, addr_bit22, addr_bit21,
      addr_bit3} <= in;
    @(negedge clock);
    zl = write_data_latch_n;
    @(posedge clock);
    cycle_start <= 1'h0;
  endtask

  task automatic wait_rdy(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (processor_ready_n !== 1'h0 && n < 60);
  endtask

  task automatic svc(output logic [7:0] both, lb, rc, tc, output logic mg);
    {both, lb, rc, tc, mg} = '0;
    {xs, rd, sr} = '0;
    for (int i = 1; i <= 60; i++) begin
      @(negedge clock);
      if (merged_service_request_n === 1'h0) mg = 1'h1;
      if ({row_strobe_buffer_one_n, row_strobe_buffer_zero_n} === 2'h0) begin
        both++;
        lb = 8'(i);
      end
      if (renew_request_clear_n === 1'h0) rc = 8'(i);
      if (transfer_request_clear_n === 1'h0) tc = 8'(i);
      // transfer strobe and serial column address stand together
      if ({serial_col_addr_enable_n, output_or_transfer_strobe_n} === 2'h0)
        xs++;
      if (row_strobe_delay_n === 1'h0) rd++;
      if (serial_row_addr_enable_n === 1'h0) sr++;
    end
  endtask

  initial begin
    int n;
    logic zl, mg;
    logic [7:0] both, lb, rc, tc, px, sk;
    {cycle_start, write_cycle, addr_bit22, addr_bit21, addr_bit3} = 5'h00;
    {expansion_space_select_n, same_page_indicator_n, renew_kick} = 3'h4;
    {dram_busy_n, other_busy_n, line_blank, zero_wait_mode} = 4'hc;
    video_data = 32'h44332211;
    repeat (5) @(posedge clock);
    arst_n <= 1'h1;
    @(negedge clock);
    chk({strobes, memory_write_strobe_n, merged_service_request_n,
      cycle_pending_n, processor_ready_n, ports}, 12'hffd);
    $display("test reset done");
    foreach (rows[i]) begin
      go(rows[i].in, zl);
      wait_rdy(n);
      chk(n, rows[i].n);
      chk(strobes, rows[i].v);
      chk({row_addr_enable_n, col_addr_enable_n}, {1'h1, rows[i].v[3]});
      chk(memory_write_strobe_n, rows[i].v[1]);
      repeat (12) @(negedge clock);
      chk(ports, rows[i].p);
    end
    chk(captures, 8'h02);
    $display("test table done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      dram_busy_n <= k[0];
      go(k[0] ? 5'h08 : 5'h00, zl);
      n = 0;
      repeat (8) begin
        @(negedge clock);
        if (cycle_pending_n !== 1'h1) n++;
      end
      chk(n, 0);
    end
    @(posedge clock);
    zero_wait_mode <= 1'h1;
    go(5'h00, zl);
    chk(zl, 1'h0);
    @(negedge clock);
    chk({expansion_busy_n, combined_busy_n}, 2'h0);
    repeat (12) @(negedge clock);
    @(posedge clock);
    {zero_wait_mode, other_busy_n} <= 2'h0;
    @(negedge clock);
    chk({expansion_busy_n, combined_busy_n}, 2'h2);
    @(posedge clock);
    other_busy_n <= 1'h1;
    go(5'h00, zl);
    repeat (2) @(posedge clock);
    {cycle_start, write_cycle} <= 2'h3;
    @(posedge clock);
    cycle_start <= 1'h0;
    wait_rdy(n);
    chk({n < 60, read_data_latch_n, write_data_latch_n}, 3'h6);
    $display("test refusal and write after read done");
    repeat (12) @(posedge clock);
    renew_kick <= 1'h1;
    @(posedge clock);
    renew_kick <= 1'h0;
    svc(both, lb, rc, tc, mg);
    chk(both, 8'h05);
    chk(rc, lb);
    chk({tc, mg}, 9'h001);
    chk({xs, rd, sr}, 24'h000100);
    @(posedge clock);
    line_blank <= 1'h1;
    svc(both, lb, rc, tc, mg);
    chk(both, 8'h05);
    chk({tc, rc, mg}, {lb, 9'h001});
    chk({xs, rd, sr}, 24'h050101);
    $display("test service done");
    @(posedge clock);
    line_blank <= 1'h0;
    n = 0;
    {px, sk} = '0;
    for (int i = 0; i < 5000 && shift_register_empty_clear_n !== 1'h0; i++)
    begin
      @(negedge clock);
      if (serial_clock === 1'h1) sk++;
      if (shift_register_load_n === 1'h0) begin
        n++;
        // first pixel of the load shows one clock later
        if (n == 1) begin
          @(negedge clock);
          px = pixel_out;
        end
      end
    end
    chk(n, 32'd256);
    chk(shift_register_empty_clear_n, 1'h0);
    chk(sk, 8'h00);
    chk(px, 8'h11);
    $display("test serial done");
    go(5'h00, zl);
    @(posedge clock);
    {line_blank, renew_kick} <= 2'h3;
    @(posedge clock);
    renew_kick <= 1'h0;
    svc(both, lb, rc, tc, mg);
    chk(both, 8'h0a);
    chk({rc < tc, tc}, {1'h1, lb});
    chk({xs, rd, sr}, 24'h050201);
    $display("test priority done");
    results();
  end
endmodule // vfb_ctrl_test

bind vfb_ctrl vfb_ctrl_asserts chk_i (.*);
